// *** dac_ctrl_pkg.sv ***
// Package of constants for the quad converter serial control block
`default_nettype none
package dac_ctrl_pkg;
   // ====================================================================
   // Frame layout
   localparam int FRAME_BITS = 16;
   localparam int CODE_W = 10;
   localparam int CMD_W = 4;
   localparam int CHANNELS = 4;
   localparam int CMD_MSB = 15;
   localparam int CMD_LSB = 12;
   localparam int CODE_MSB = 11;
   localparam int CODE_LSB = 2;
   localparam int SUB_MSB = 1;
   localparam int SUB_LSB = 0;
   localparam int SEL_MSB = 4;
   localparam int SEL_LSB = 2;
   localparam logic [4:0] LAST_BIT_COUNT = 5'h0F;
   localparam logic [4:0] FULL_COUNT = 5'h10;

   // ====================================================================
   // Command codes
   localparam logic [1:0] GRP_TRANSPARENT = 2'h0;
   localparam logic [1:0] GRP_LOAD = 2'h1;
   localparam logic [1:0] GRP_COPY = 2'h2;
   localparam logic [3:0] CMD_ALL_TRANSPARENT = 4'hC;
   localparam logic [3:0] CMD_ALL_LOAD = 4'hD;
   localparam logic [3:0] CMD_ALL_COPY = 4'hE;
   localparam logic [3:0] CMD_POWER = 4'hF;
   localparam logic [2:0] SEL_ALL = 3'h4;

   // ====================================================================
   // Output states of a channel
   localparam logic [1:0] PD_AWAKE = 2'h0;
   localparam logic [1:0] PD_FLOAT = 2'h1;
   localparam logic [1:0] PD_1K = 2'h2;
   localparam logic [1:0] PD_100K = 2'h3;

   // ====================================================================
   // Reset values and timing
   localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
   localparam logic [1:0] PD_RESET = PD_100K;
   localparam int CLOCK_MHZ = 25;
   localparam int WAKE_US = 8;
   localparam int WAKE_CYCLES = WAKE_US * CLOCK_MHZ;
   localparam logic [7:0] WAKE_COUNT = 8'(WAKE_CYCLES);
endpackage : dac_ctrl_pkg
`default_nettype wire

// *** frame_if.sv ***
// Interface carrying a completed frame from the serial receiver to the register logic
`default_nettype none
interface frame_if;
   import dac_ctrl_pkg::*;
   logic [FRAME_BITS-1:0] word;
   logic done;
   modport rx (output word, output done);
   modport core (input word, input done);
endinterface : frame_if
`default_nettype wire

// *** serial_rx.sv ***
// Serial receiver: samples the link pins and assembles 16-bit frames
`default_nettype none
module serial_rx
   import dac_ctrl_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic cs_n_pin,
   input wire logic sclk_pin,
   input wire logic din_pin,
   frame_if.rx frame
);
   // ====================================================================
   // Pin synchronisers
   logic [2:0] cs_sync_reg;
   logic [2:0] sclk_sync_reg;
   logic [2:0] din_sync_reg;
   logic cs_level_reg;
   logic sclk_level_reg;
   logic din_level_reg;
   logic [FRAME_BITS-1:0] shift_reg;
   logic [4:0] count_reg;
   logic armed_reg;
   logic cs_fall;
   logic cs_rise;
   logic sclk_fall;

   // Three stages; a level counts once stages two and three agree
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         cs_sync_reg <= 3'h7;
         sclk_sync_reg <= 3'h0;
         din_sync_reg <= 3'h0;
      end else begin
         cs_sync_reg <= {cs_sync_reg[1:0], cs_n_pin};
         sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_pin};
         din_sync_reg <= {din_sync_reg[1:0], din_pin};
      end
   end

   // Filtered levels, held while stages two and three disagree
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         cs_level_reg <= 1'b1;
         sclk_level_reg <= 1'b0;
         din_level_reg <= 1'b0;
      end else begin
         if (cs_sync_reg[1] == cs_sync_reg[2]) cs_level_reg <= cs_sync_reg[2];
         if (sclk_sync_reg[1] == sclk_sync_reg[2]) sclk_level_reg <= sclk_sync_reg[2];
         if (din_sync_reg[1] == din_sync_reg[2]) din_level_reg <= din_sync_reg[2];
      end
   end

   assign cs_fall = cs_level_reg && (cs_sync_reg[1] == cs_sync_reg[2]) && !cs_sync_reg[2];
   assign cs_rise = !cs_level_reg && (cs_sync_reg[1] == cs_sync_reg[2]) && cs_sync_reg[2];
   // Only falling edges shift, so the idle level of the clock does not matter
   assign sclk_fall = sclk_level_reg && (sclk_sync_reg[1] == sclk_sync_reg[2]) && !sclk_sync_reg[2];

   // ====================================================================
   // Frame assembly
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         shift_reg <= '0;
         count_reg <= 5'h00;
         armed_reg <= 1'b0;
         frame.done <= 1'b0;
      end else begin
         frame.done <= 1'b0;
         if (cs_fall) begin
            // Fresh frame only on a new falling chip select
            count_reg <= 5'h00;
            armed_reg <= 1'b1;
         end else if (cs_rise) begin
            // Partial word is dropped, nothing is written
            armed_reg <= 1'b0;
         end else if (armed_reg && !cs_level_reg && sclk_fall) begin
            // Data taken on the falling serial clock edge
            shift_reg <= {shift_reg[FRAME_BITS-2:0], din_level_reg};
            count_reg <= count_reg + 5'h01;
            if (count_reg == LAST_BIT_COUNT) begin
               // Act at once on bit sixteen, then ignore edges
               frame.done <= 1'b1;
               armed_reg <= 1'b0;
            end
         end
      end
   end

   assign frame.word = shift_reg;
endmodule : serial_rx
`default_nettype wire

// *** quad_dac_serial_control.sv ***
// Top level of the quad converter control: command decode, channel registers, power state
`default_nettype none
// Overview of operation
// - Four channels, each takes a 10-bit unsigned code scaling the reference
// - Codes are straight binary, zero is zero scale, 1023 full scale
// - Reset zeroes output registers, buffers off, outputs at 100k termination
// - One channel or all four can be powered down by a frame
// - Power-down leaves holding and output registers untouched
// - Wake restores the output from the kept output register code
// - Command 1111 powers down; select 000-011 one channel, 100 all
// - Subfield 00 wake, 01 float, 10 one kilohm, 11 hundred kilohm
// - Recovery from full power-down takes eight microseconds before valid
// - Data sampled on serial clock falling edges after chip select falls
// - After sixteen bits the word acts at once, no chip select rise needed
// - Chip select rising early discards the partial word
// - Serial clock may idle at either level
// - Each channel has a holding register and an output register
// - Holding registers can load without touching outputs
// - Transparent writes go straight to the output register
// - Output changes only when its output register is written
// - Frame is four command, ten code, two subfield bits, MSB first
// - Command codes for transparent, load, copy, and their all-channel forms
// - Reset also clears holding registers and powers down all channels
module quad_dac_serial_control
   import dac_ctrl_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   output logic [CHANNELS*CODE_W-1:0] channel_outputs,
   output logic [CHANNELS*2-1:0] power_state,
   output logic [CHANNELS-1:0] buffer_enable,
   output logic [CHANNELS-1:0] output_valid,
   output logic bias_ready
);
   // ====================================================================
   // Serial receiver
   frame_if frame ();

   serial_rx rx (
      .clock(clock),
      .reset_n(reset_n),
      .cs_n_pin(cs_n),
      .sclk_pin(sclk),
      .din_pin(din),
      .frame(frame)
   );

   // ====================================================================
   // Frame fields
   logic [CMD_W-1:0] command_code;
   logic [CODE_W-1:0] channel_code;
   logic [1:0] trailing_subfield;
   logic [2:0] target_select;
   logic all_channel_select;

   assign command_code = frame.word[CMD_MSB:CMD_LSB];
   assign channel_code = frame.word[CODE_MSB:CODE_LSB]; // Plain binary code
   assign trailing_subfield = frame.word[SUB_MSB:SUB_LSB];
   assign target_select = frame.word[SEL_MSB:SEL_LSB]; // Upper code bits ignored
   assign all_channel_select = (target_select == SEL_ALL);

   // ====================================================================
   // Per-channel write strobes decoded from the command
   logic [CHANNELS-1:0] load_hold;
   logic [CHANNELS-1:0] load_out_direct;
   logic [CHANNELS-1:0] load_out_copy;
   logic [CHANNELS-1:0] set_power;

   always_comb begin
      load_hold = '0;
      load_out_direct = '0;
      load_out_copy = '0;
      set_power = '0;
      if (frame.done) begin
         if (command_code == CMD_POWER) begin
            // Single channel or all four
            if (all_channel_select) set_power = '1;
            else if (!target_select[2]) set_power[target_select[1:0]] = 1'b1;
         end else if (command_code == CMD_ALL_TRANSPARENT) begin
            load_hold = '1;
            load_out_direct = '1;
         end else if (command_code == CMD_ALL_LOAD) begin
            load_hold = '1; // Outputs untouched
         end else if (command_code == CMD_ALL_COPY) begin
            load_out_copy = '1;
         end else begin
            case (command_code[3:2])
               GRP_TRANSPARENT: begin
                  load_hold[command_code[1:0]] = 1'b1;
                  load_out_direct[command_code[1:0]] = 1'b1;
               end
               GRP_LOAD: load_hold[command_code[1:0]] = 1'b1;
               GRP_COPY: load_out_copy[command_code[1:0]] = 1'b1;
               default: ;
            endcase
         end
      end
   end

   // ====================================================================
   // Channel registers
   logic [CODE_W-1:0] hold_reg [CHANNELS];
   logic [CODE_W-1:0] out_reg [CHANNELS];
   logic [1:0] pd_reg [CHANNELS];

   // Holding registers; kept across power-down
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         for (int i = 0; i < CHANNELS; i++) hold_reg[i] <= CODE_RESET;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (load_hold[i]) hold_reg[i] <= channel_code;
         end
      end
   end

   // Output registers change only on a direct or copy write
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         for (int i = 0; i < CHANNELS; i++) out_reg[i] <= CODE_RESET;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (load_out_direct[i]) out_reg[i] <= channel_code;
            else if (load_out_copy[i]) out_reg[i] <= hold_reg[i];
         end
      end
   end

   // Power state per channel
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         for (int i = 0; i < CHANNELS; i++) pd_reg[i] <= PD_RESET;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (set_power[i]) pd_reg[i] <= trailing_subfield;
         end
      end
   end

   // ====================================================================
   // Bias recovery timer: restarts when leaving full power-down
   // The timer only flags validity; it refuses nothing, the host owns the wait
   logic all_down;
   logic all_down_reg;
   logic [7:0] wake_count_reg;

   always_comb begin
      all_down = 1'b1;
      for (int i = 0; i < CHANNELS; i++) begin
         if (pd_reg[i] == PD_AWAKE) all_down = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         all_down_reg <= 1'b1;
         wake_count_reg <= 8'h00;
      end else begin
         all_down_reg <= all_down;
         if (all_down) wake_count_reg <= 8'h00;
         else if (all_down_reg) wake_count_reg <= WAKE_COUNT;
         else if (wake_count_reg != 8'h00) wake_count_reg <= wake_count_reg - 8'h01;
      end
   end

   // ====================================================================
   // Registered outputs; codes persist through power-down
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         channel_outputs <= '0;
         power_state <= {CHANNELS{PD_RESET}};
         buffer_enable <= '0; // Buffers off at reset
         output_valid <= '0;
         bias_ready <= 1'b0;
      end else begin
         bias_ready <= !all_down && (wake_count_reg == 8'h00) && !all_down_reg;
         for (int i = 0; i < CHANNELS; i++) begin
            channel_outputs[i*CODE_W +: CODE_W] <= out_reg[i];
            power_state[i*2 +: 2] <= pd_reg[i];
            buffer_enable[i] <= (pd_reg[i] == PD_AWAKE);
            output_valid[i] <= (pd_reg[i] == PD_AWAKE) && (wake_count_reg == 8'h00) && !all_down_reg;
         end
      end
   end
endmodule : quad_dac_serial_control
`default_nettype wire

// *** quad_dac_sva.sv ***
// Assertion checker for the ports of the quad converter serial control block
`default_nettype none
module quad_dac_sva
   import dac_ctrl_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic [CHANNELS*CODE_W-1:0] channel_outputs,
   input wire logic [CHANNELS*2-1:0] power_state,
   input wire logic [CHANNELS-1:0] buffer_enable,
   input wire logic [CHANNELS-1:0] output_valid,
   input wire logic bias_ready
);
   // ====================================================================
   // Helper logic
   logic [4:0] idle_reg;
   logic [8:0] awake_reg;
   logic [3:0] up;
   // Awake channels as decoded from the reported power state
   assign up = {power_state[7:6] == 2'h0, power_state[5:4] == 2'h0, power_state[3:2] == 2'h0, power_state[1:0] == 2'h0};
   // Cycles with chip select high; saturates so a long idle stays flagged
   always_ff @(posedge clock) begin
      if (!reset_n || !cs_n) idle_reg <= 5'h00;
      else if (idle_reg != 5'h1F) idle_reg <= idle_reg + 5'h01;
   end
   // Cycles since the first buffer came on after all were off
   always_ff @(posedge clock) begin
      if (!reset_n || buffer_enable == 4'h0) awake_reg <= 9'h000;
      else if (awake_reg != 9'h1FF) awake_reg <= awake_reg + 9'h001;
   end
   // ====================================================================
   // Assertions
   reset_vals_a: assert property (@(posedge clock)
      !reset_n |=> channel_outputs == '0 && power_state == 8'hFF && buffer_enable == 4'h0)
      else $error("reset values wrong");
   buf_follow_a: assert property (@(posedge clock) disable iff (!reset_n)
      buffer_enable == up)
      else $error("buffer enable does not follow power state");
   valid_buf_a: assert property (@(posedge clock) disable iff (!reset_n)
      (output_valid & ~buffer_enable) == 4'h0)
      else $error("valid on a powered down channel");
   bias_any_a: assert property (@(posedge clock) disable iff (!reset_n)
      bias_ready == (|output_valid))
      else $error("bias ready disagrees with channel validity");
   quiet_regs_a: assert property (@(posedge clock) disable iff (!reset_n)
      idle_reg == 5'h1F |-> $stable(channel_outputs) && $stable(power_state))
      else $error("state changed with no frame");
   pd_keeps_a: assert property (@(posedge clock) disable iff (!reset_n)
      $changed(power_state) |-> $stable(channel_outputs))
      else $error("power command changed a code");
   wake_early_a: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(bias_ready) |-> awake_reg >= 9'h0C3)
      else $error("bias ready before recovery time");
   wake_late_a: assert property (@(posedge clock) disable iff (!reset_n)
      awake_reg == 9'h0D2 |-> bias_ready)
      else $error("bias ready late");
endmodule : quad_dac_sva
bind quad_dac_serial_control quad_dac_sva chk (.clock(clock), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk),
   .din(din), .channel_outputs(channel_outputs), .power_state(power_state), .buffer_enable(buffer_enable),
   .output_valid(output_valid), .bias_ready(bias_ready));
`default_nettype wire

// *** dac_host.sv ***
// Behavioural serial master that drives chip select, serial clock and data
`default_nettype none
module dac_host (
   input wire logic clock,
   output logic cs_n,
   output logic sclk,
   output logic din
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle pins at time zero
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end
   // Sends nbits MSB first; half sclk period is 4 clocks, so 320 ns per bit
   task automatic frame(input logic [15:0] w, input int nbits, input logic idle, input logic hold);
      if (!cs_n) begin
         cs_n = 1'b1;
         repeat (4) @(negedge clock);
      end
      sclk = idle;
      repeat (4) @(negedge clock);
      cs_n = 1'b0;
      repeat (4) @(negedge clock);
      for (int i = 0; i < nbits; i++) begin
         din = w[4'(15 - i)];
         sclk = 1'b1;
         repeat (4) @(negedge clock);
         sclk = 1'b0;
         repeat (4) @(negedge clock);
      end
      sclk = idle;
      // Released data line shows the inverse so a stale bit cannot pass
      if (!hold) begin
         cs_n = 1'b1;
         din = ~din;
      end
      repeat (4) @(negedge clock);
   endtask : frame
endmodule : dac_host
`default_nettype wire

// *** quad_dac_serial_control_test.sv ***
// Self-checking bench for the quad converter serial control block
`default_nettype none
module quad_dac_serial_control_test
   import dac_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic cs_n, sclk, din, bias_ready;
   logic [39:0] channel_outputs;
   logic [7:0] power_state;
   logic [3:0] buffer_enable, output_valid;
   logic [39:0] exp_out = '0;
   logic [7:0] exp_ps = 8'hFF;
   logic [9:0] codes [4] = '{10'h3FF, 10'h001, 10'h200, 10'h155};
   int n_mismatch = 0;
   int total_checks = 0;
   int cycles = 0;
   always #20 clock = ~clock;
   dac_host host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .din(din));
   quad_dac_serial_control uut (.clock(clock), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .din(din),
      .channel_outputs(channel_outputs), .power_state(power_state), .buffer_enable(buffer_enable),
      .output_valid(output_valid), .bias_ready(bias_ready));
   // ====================================================================
   // Shared tasks
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test
   // Cut a hang short; the tests need about 6200 cycles
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 12000) begin
         n_mismatch++;
         $display("BAD %0t timeout", $time);
         end_of_test();
      end
   end
   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Compares codes, power states and buffers with the expected state
   task automatic expect_all();
      logic [3:0] up;
      for (int c = 0; c < 4; c++) up[c] = exp_ps[2*c +: 2] == PD_AWAKE;
      check(channel_outputs, exp_out);
      check(40'(power_state), 40'(exp_ps));
      check(40'(buffer_enable), 40'(up));
   endtask : expect_all
   // Whole frame, then time for the write to land
   task automatic send(input logic [15:0] w);
      host.frame(w, 16, 1'b0, 1'b0);
      repeat (10) @(negedge clock);
   endtask : send
   // ====================================================================
   // Scenarios
   task automatic test_transparent();
      for (int c = 0; c < 4; c++) begin
         send({GRP_TRANSPARENT, 2'(c), codes[c], 2'b00});
         exp_out[c*10 +: 10] = codes[c];
         expect_all();
      end
      $display("test_transparent done");
   endtask : test_transparent
   task automatic test_load_copy();
      for (int c = 0; c < 4; c++) begin
         send({GRP_LOAD, 2'(c), ~codes[c], 2'b00});
         expect_all();
      end
      for (int c = 0; c < 4; c++) begin
         send({GRP_COPY, 2'(c), 10'h3C3, 2'b00});
         exp_out[c*10 +: 10] = ~codes[c];
         expect_all();
      end
      send({CMD_ALL_LOAD, 10'h2AA, 2'b00});
      expect_all();
      send({CMD_ALL_COPY, 10'h000, 2'b00});
      exp_out = {4{10'h2AA}};
      expect_all();
      send({CMD_ALL_TRANSPARENT, 10'h0F0, 2'b00});
      exp_out = {4{10'h0F0}};
      expect_all();
      $display("test_load_copy done");
   endtask : test_load_copy
   task automatic test_power();
      for (int s = 3; s >= 0; s--) begin
         for (int c = 0; c <= 4; c++) begin
            send({CMD_POWER, 7'h55, 3'(c), 2'(s)});
            if (c == 4) exp_ps = {4{2'(s)}};
            else exp_ps[2*c +: 2] = 2'(s);
            expect_all();
            if (s == 0 && c == 0) check(40'(output_valid), 40'h0);
         end
      end
      // Host waits out the bias recovery before any output write
      repeat (210) @(negedge clock);
      check(40'({bias_ready, output_valid}), 40'h1F);
      $display("test_power done");
   endtask : test_power
   task automatic test_abort();
      host.frame({GRP_TRANSPARENT, 2'h0, 10'h3FF, 2'b00}, 7, 1'b0, 1'b0);
      repeat (10) @(negedge clock);
      expect_all();
      host.frame({GRP_TRANSPARENT, 2'h1, 10'h111, 2'b00}, 15, 1'b1, 1'b0);
      repeat (10) @(negedge clock);
      expect_all();
      send({CMD_POWER, 7'h00, 3'h5, 2'h3});
      expect_all();
      host.frame({GRP_TRANSPARENT, 2'h2, 10'h123, 2'b00}, 20, 1'b1, 1'b1);
      exp_out[20 +: 10] = 10'h123;
      expect_all();
      send({GRP_TRANSPARENT, 2'h3, 10'h0AA, 2'b00});
      exp_out[30 +: 10] = 10'h0AA;
      expect_all();
      $display("test_abort done");
   endtask : test_abort
   // Main sequence
   initial begin
      repeat (8) @(negedge clock);
      reset_n = 1'b1;
      repeat (2) @(negedge clock);
      expect_all();
      check(40'({bias_ready, output_valid}), 40'h0);
      $display("test_reset done");
      test_transparent();
      test_load_copy();
      test_power();
      test_abort();
      end_of_test();
   end
endmodule : quad_dac_serial_control_test
`default_nettype wire
